// File: dv/aas_adc_model.sv
// Behavioural input multiplexer and comparator on the far side of the sequencer.
// Assumes the bench sets the eight input levels and the design steps the trial code.
`timescale 1ns/10ps
module aas_adc_model (
  input  wire        clock,
  input  wire [63:0] levels,
  input  wire [2:0]  chan,
  input  wire [7:0]  trial,
  input  wire        busy,
  output wire        comp_out
);
  reg  last_r = 1'b0;
  wire cmp = levels[8*chan +: 8] >= trial;
  // An idle comparator toggles so that a stale decision is never trusted.
  assign comp_out = busy ? cmp : ~last_r;
  always @(posedge clock)
    last_r <= comp_out;
endmodule // aas_adc_model

// File: dv/aas_seq_chk.sv
// Concurrent checks on the autoscan sequencer ports.
// Assumes it is bound to the sequencer top and sees its ports only.
`timescale 1ns/10ps
module aas_seq_chk #(
  parameter CONV_CYCLES   = 138,
  parameter SAMPLE_CYCLES = 84
) (
  input wire        clock,
  input wire        rst_n,
  input wire        ctrl_wr,
  input wire        thr_wr,
  input wire [3:0]  thr_addr,
  input wire [7:0]  thr_wdata,
  input wire        irq_ctrl_wr,
  input wire [7:0]  irq_ctrl_wdata,
  input wire        wa_irq_enable,
  input wire        halt_entry,
  input wire [7:0]  control_word,
  input wire        conversion_run_r,
  input wire        analog_bias_on_r,
  input wire [7:0]  compare_flags,
  input wire        end_of_sequence_flag_r,
  input wire        window_alarm_flag_r,
  input wire [1:0]  irq_source_r,
  input wire [7:0]  lt6_r,
  input wire [2:0]  mux_chan_r,
  input wire        sample_on,
  input wire        conv_busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  reg [7:0] busy_cnt_r;
  always @(posedge clock)
    busy_cnt_r <= (!rst_n || !conv_busy) ? 8'h00 : busy_cnt_r + 8'h01;
  //////////////////////////////////////////////////////////////////////////////
  // sample phase, conversion length, flags, run control, bias, thresholds and priority
  property p_sample; conv_busy && !$past(ctrl_wr) |-> sample_on == (busy_cnt_r < SAMPLE_CYCLES);
  endproperty
  a_sample: assert property (p_sample) else $error("sample phase length wrong");
  property p_len; $fell(conv_busy) && !$past(ctrl_wr) && !$past(ctrl_wr, 2) |-> busy_cnt_r == CONV_CYCLES;
  endproperty
  a_len: assert property (p_len) else $error("conversion length wrong");
  property p_ones; compare_flags[3:0] == 4'hF; endproperty
  a_ones: assert property (p_ones) else $error("compare low nibble not ones");
  property p_eos; $fell(conv_busy) && mux_chan_r == 3'h7 && !ctrl_wr && !irq_ctrl_wr
    && busy_cnt_r == CONV_CYCLES |=> end_of_sequence_flag_r; endproperty
  a_eos: assert property (p_eos) else $error("no end flag after last channel");
  property p_stop; $fell(conversion_run_r) && !$past(ctrl_wr) && !$past(irq_ctrl_wr)
    |-> end_of_sequence_flag_r && !control_word[1]; endproperty
  a_stop: assert property (p_stop) else $error("run cleared without end flag");
  property p_gate; !conversion_run_r && !ctrl_wr && control_word[4:3] == 2'b00
    |=> !conversion_run_r; endproperty
  a_gate: assert property (p_gate) else $error("run set with triggers disabled");
  property p_halt; halt_entry |=> !analog_bias_on_r; endproperty
  a_halt: assert property (p_halt) else $error("bias kept over halt");
  property p_thr; thr_wr |=> lt6_r == ($past(thr_addr) == 4'h8 ? $past(thr_wdata) : $past(lt6_r));
  endproperty
  a_thr: assert property (p_thr) else $error("threshold write wrong");
  property p_clr; irq_ctrl_wr && !irq_ctrl_wdata[6] && !$past(conv_busy)
    |=> compare_flags[7:4] == 4'h0; endproperty
  a_clr: assert property (p_clr) else $error("compare flags not cleared");
  property p_alarm; $rose(window_alarm_flag_r) && !$past(irq_ctrl_wr) |-> compare_flags[7:4] != 4'h0;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm without compare flag");
  property p_prio; window_alarm_flag_r && wa_irq_enable |=> irq_source_r == 2'h1; endproperty
  a_prio: assert property (p_prio) else $error("alarm not served first");
  c_stop: cover property ($fell(conversion_run_r));
  c_eos: cover property ($rose(end_of_sequence_flag_r));
  c_alarm: cover property ($rose(window_alarm_flag_r));
endmodule // aas_seq_chk
bind aas_seq aas_seq_chk #(.CONV_CYCLES(CONV_CYCLES), .SAMPLE_CYCLES(SAMPLE_CYCLES))
  u_chk (.*);

// File: dv/aas_seq_tb.sv
// Self-checking bench for the autoscan sequencer against expected values worked out from the input levels.
// Assumes the behavioural converter model and the bound checker.
`timescale 1ns/10ps
module aas_seq_tb;
  reg         clock = 1'b0, rst_n = 1'b0, ctrl_wr = 1'b0, thr_wr = 1'b0;
  reg         irq_ctrl_wr = 1'b0, halt_entry = 1'b0, eos_irq_enable = 1'b1;
  reg         wa_irq_enable = 1'b1, pin_trigger_input = 1'b1, timer_trigger_input = 1'b1;
  reg  [7:0]  ctrl_wdata = 8'h00, thr_wdata = 8'h00, irq_ctrl_wdata = 8'h00;
  reg  [3:0]  thr_addr = 4'h0, exp_cmp = 4'h0;
  reg  [2:0]  irq_priority = 3'h5;
  reg  [63:0] levels = 64'h0;
  reg  [31:0] seed = 32'h301D;
  wire        comp_in, conversion_run_r, analog_bias_on_r, end_of_sequence_flag_r;
  wire        window_alarm_flag_r, sample_on, conv_busy;
  wire [7:0]  control_word, compare_flags, sar_trial, lt6_r, lt7_r, ut6_r, ut7_r;
  wire [1:0]  irq_source_r;
  wire [2:0]  irq_level_r, mux_chan_r;
  wire [63:0] channel_data_r;
  integer     checks = 0, n_errors = 0, i, k, rep;
  integer     exp_data [0:7];
  aas_seq DUT (.*);
  aas_adc_model u_adc (.clock(clock), .levels(levels), .chan(mux_chan_r), .trial(sar_trial),
    .busy(conv_busy), .comp_out(comp_in));
  always #2.5 clock = ~clock;
  //////////////////////////////////////////////////////////////////////////////
  task check(input [63:0] seen, input [63:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp)
      begin
        n_errors = n_errors + 1;
        $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task pulse(input integer sel, input [7:0] d, input [3:0] a);
    begin
      @(negedge clock);
      ctrl_wdata = d;
      thr_wdata = d;
      irq_ctrl_wdata = d;
      thr_addr = a;
      ctrl_wr = sel == 0;
      thr_wr = sel == 1;
      irq_ctrl_wr = sel == 2;
      @(negedge clock);
      {ctrl_wr, thr_wr, irq_ctrl_wr} = 3'h0;
    end
  endtask
  task trig(input integer pin);
    begin
      @(negedge clock);
      if (pin) pin_trigger_input = 1'b0;
      else timer_trigger_input = 1'b0;
      @(negedge clock);
      {pin_trigger_input, timer_trigger_input} = 2'h3;
    end
  endtask
  task wait_for(input integer eos);
    begin
      k = 0;
      while ((eos ? end_of_sequence_flag_r : !conversion_run_r) !== 1'b1 && k < 3000)
      begin
        @(negedge clock);
        k = k + 1;
      end
      check(k < 3000, 1);
    end
  endtask
  task new_levels;
    for (i = 0; i < 8; i = i + 1)
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      levels[8*i +: 8] = seed[7:0];
    end
  endtask
  task seq_done(input integer lo);
    begin
      for (i = lo; i < 8; i = i + 1) exp_data[i] = levels[8*i +: 8];
      exp_cmp = exp_cmp | {levels[63:56] >= 8'hE0, lo <= 6 && levels[55:48] >= 8'hC0,
        levels[63:56] < 8'h20, lo <= 6 && levels[55:48] < 8'h40};
      for (i = 0; i < 8; i = i + 1) check(channel_data_r[8*i +: 8], exp_data[i]);
      check(compare_flags, {exp_cmp, 4'hF});
      check(window_alarm_flag_r, |exp_cmp);
    end
  endtask
  initial
  begin
    #200000;
    n_errors = n_errors + 1;
    final_report;
  end
  initial
  begin
    for (i = 0; i < 8; i = i + 1) exp_data[i] = 0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    check(compare_flags, 8'h0F);
    check({conversion_run_r, analog_bias_on_r}, 0);
    pulse(1, 8'h40, 4'h8);
    pulse(1, 8'h20, 4'h9);
    pulse(1, 8'hC0, 4'hA);
    pulse(1, 8'hE0, 4'hB);
    pulse(1, 8'h11, 4'hC);
    check({lt6_r, lt7_r, ut6_r, ut7_r}, 32'h4020C0E0);
    pulse(0, 8'h04, 4'h0);
    repeat (12000) @(negedge clock);
    new_levels;
    levels[63:56] = 8'hF0;
    pulse(0, 8'h65, 4'h0);
    wait_for(0);
    seq_done(3);
    check(end_of_sequence_flag_r, 1);
    pulse(2, 8'h00, 4'h0);
    exp_cmp = 4'h0;
    check({end_of_sequence_flag_r, compare_flags}, 9'h00F);
    new_levels;
    pulse(0, 8'hF4, 4'h0);
    trig(0);
    repeat (2) @(negedge clock);
    check(conversion_run_r, 0);
    trig(1);
    @(negedge clock);
    check(conversion_run_r, 1);
    wait_for(0);
    seq_done(7);
    pulse(0, 8'hCE, 4'h0);
    for (rep = 0; rep < 3; rep = rep + 1)
    begin
      pulse(2, 8'h00, 4'h0);
      exp_cmp = 4'h0;
      trig(0);
      wait_for(1);
      seq_done(6);
      check(conversion_run_r, 1);
      new_levels;
    end
    pulse(0, 8'h04, 4'h0);
    repeat (3) @(negedge clock);
    check({conversion_run_r, conv_busy}, 0);
    pulse(2, 8'hC0, 4'h0);
    repeat (2) @(negedge clock);
    check({irq_source_r, irq_level_r, end_of_sequence_flag_r}, 6'h1B);
    pulse(2, 8'h80, 4'h0);
    eos_irq_enable = 1'b0;
    repeat (2) @(negedge clock);
    check({irq_source_r, irq_level_r}, 0);
    check(analog_bias_on_r, 1);
    halt_entry = 1'b1;
    @(negedge clock);
    halt_entry = 1'b0;
    check(analog_bias_on_r, 0);
    final_report;
  end
endmodule // aas_seq_tb

// File: rtl/aas_defines.vh
// Shared constants for the autoscan converter sequencer.
// Assumes inclusion by bare name from every design file of the block.
`ifndef AAS_DEFINES_VH
`define AAS_DEFINES_VH

// Conversion timing in core clock cycles and result width in bits.
`define AAS_CONV_CYCLES      138
`define AAS_SAMPLE_CYCLES    84
`define AAS_BIT_CYCLES       6
`define AAS_RES_BITS         8

// Control word field positions.
`define AAS_CTL_RUN          0
`define AAS_CTL_CONT         1
`define AAS_CTL_BIAS         2
`define AAS_CTL_TMR_EN       3
`define AAS_CTL_PIN_EN       4
`define AAS_CTL_FCS_LO       5
`define AAS_CTL_FCS_HI       7
`define AAS_CTL_RESET        8'h00

// Interrupt control word field positions.
`define AAS_ICR_EOS          7
`define AAS_ICR_WA           6

// Threshold page offsets.
`define AAS_THR_LT6          4'h8
`define AAS_THR_LT7          4'h9
`define AAS_THR_UT6          4'hA
`define AAS_THR_UT7          4'hB

// Compare flag layout: upper nibble flags, lower nibble reads as ones.
`define AAS_CMP_C7U          7
`define AAS_CMP_C6U          6
`define AAS_CMP_C7L          5
`define AAS_CMP_C6L          4
`define AAS_CMP_LOW_ONES     4'hF
`define AAS_CMP_RESET        8'h0F

// Interrupt source codes.
`define AAS_SRC_NONE         2'h0
`define AAS_SRC_WA           2'h1
`define AAS_SRC_EOS          2'h2

`define AAS_LAST_CHAN        3'h7
`define AAS_MON_CHAN_A       3'h6

`endif

// File: rtl/aas_sar.v
// Sample and successive approximation timing for one channel.
// Assumes the comparator input is high when the analog input is at or above the trial code.
`timescale 1ns/10ps
`include "aas_defines.vh"

module aas_sar #(
  parameter CONV_CYCLES   = `AAS_CONV_CYCLES,
  parameter SAMPLE_CYCLES = `AAS_SAMPLE_CYCLES,
  parameter BIT_CYCLES    = `AAS_BIT_CYCLES
) (
  input  wire       clock,
  input  wire       rst_n,
  input  wire       start,
  input  wire       abort,
  input  wire       comp_in,
  output reg        busy_r,
  output reg        sample_r,
  output reg  [7:0] trial_r,
  output reg        done_r,
  output reg  [7:0] result_r
);

  reg  [7:0] cnt_r;
  reg  [7:0] work_r;
  reg  [2:0] bit_idx_r;
  reg  [2:0] sub_r;
  wire       conv_end;
  wire       bit_end;

  assign conv_end = (cnt_r == CONV_CYCLES[7:0] - 8'h01);
  assign bit_end  = (cnt_r >= SAMPLE_CYCLES[7:0]) && (sub_r == BIT_CYCLES[2:0] - 3'h1) &&
                    (cnt_r < SAMPLE_CYCLES[7:0] + 8'h30);

  always @(posedge clock)
  begin
    if (!rst_n || abort)
    begin
      busy_r    <= 1'b0;
      sample_r  <= 1'b0;
      trial_r   <= 8'h00;
      done_r    <= 1'b0;
      cnt_r     <= 8'h00;
      work_r    <= 8'h00;
      bit_idx_r <= 3'h7;
      sub_r     <= 3'h0;
      if (!rst_n)
        result_r <= 8'h00;
    end
    else
    begin
      done_r <= 1'b0;
      if (start && !busy_r)
      begin
        busy_r    <= 1'b1;
        sample_r  <= 1'b1;
        cnt_r     <= 8'h00;
        work_r    <= 8'h00;
        bit_idx_r <= 3'h7;
        sub_r     <= 3'h0;
        trial_r   <= 8'h80;
      end
      else if (busy_r)
      begin
        cnt_r <= cnt_r + 8'h01;
        if (cnt_r == SAMPLE_CYCLES[7:0] - 8'h01)
          sample_r <= 1'b0;
        if (cnt_r >= SAMPLE_CYCLES[7:0])
          sub_r <= (sub_r == BIT_CYCLES[2:0] - 3'h1) ? 3'h0 : sub_r + 3'h1;
        if (bit_end)
        begin
          work_r[bit_idx_r] <= comp_in;
          bit_idx_r         <= bit_idx_r - 3'h1;
          trial_r           <= (work_r | ({7'h00, comp_in} << bit_idx_r)) |
                               ((bit_idx_r != 3'h0) ? (8'h01 << (bit_idx_r - 3'h1)) : 8'h00);
        end
        if (conv_end)
        begin
          busy_r   <= 1'b0;
          done_r   <= 1'b1;
          result_r <= work_r;
          trial_r  <= 8'h00;
        end
      end
    end
  end

endmodule // aas_sar

// File: rtl/aas_seq.v
// Autoscan sequencer top: control word, triggers, channel stepping, data, monitors.
// Assumes all inputs synchronous to clock; software strobes are one-cycle pulses.
`timescale 1ns/10ps
`include "aas_defines.vh"

// Function
// - Conversion is 138 core cycles, first 84 of them sampling.
// - Each result is an 8-bit unsigned code against the reference.
// - Continuous bit picks continuous mode, else single; both autoscan.
// - Sequence starts at first channel, increments, stops after channel 7.
// - First channel 3 converts 3 to 7; first channel 7 converts only 7.
// - Run set by software or trigger converts channels into their registers.
// - Single mode clears run after channel 7, flags end, then idles.
// - Continuous mode restarts at first channel until software clears run.
// - End-of-sequence request raised each time channel 7 completes.
// - New result overwrites the channel register.
// - Pin and timer triggers each gated by own enable, then ORed.
// - Enabled trigger sets run; later triggers in continuous flow ignored.
// - Trigger arriving while run is set is ignored.
// - Channels 6 and 7 in range when below upper, at or above lower.
// - Out-of-range result raises window request and sets its compare flag.
// - Four thresholds writable at page offsets 08h to 0Bh.
// - Only upper four compare bits are flags; lower four read one.
// - Compare flags cleared by reset and when software clears window flag.
// - Bias is off after reset and cleared on halt entry.
// - Two maskable request channels, fixed priority, seven priority levels.
// - Window alarm served before simultaneous end-of-sequence, which stays pending.
// - Pending flags cleared only by reset or software; software set raises request.
// - Any control write aborts conversion and reinitialises sequencing.
module aas_seq #(
  parameter CONV_CYCLES   = `AAS_CONV_CYCLES,
  parameter SAMPLE_CYCLES = `AAS_SAMPLE_CYCLES,
  parameter BIT_CYCLES    = `AAS_BIT_CYCLES
) (
  input  wire        clock,
  input  wire        rst_n,
  input  wire        ctrl_wr,
  input  wire [7:0]  ctrl_wdata,
  input  wire        thr_wr,
  input  wire [3:0]  thr_addr,
  input  wire [7:0]  thr_wdata,
  input  wire        irq_ctrl_wr,
  input  wire [7:0]  irq_ctrl_wdata,
  input  wire        eos_irq_enable,
  input  wire        wa_irq_enable,
  input  wire [2:0]  irq_priority,
  input  wire        halt_entry,
  input  wire        pin_trigger_input,
  input  wire        timer_trigger_input,
  input  wire        comp_in,
  output wire [7:0]  control_word,
  output reg         conversion_run_r,
  output reg         analog_bias_on_r,
  output wire [7:0]  compare_flags,
  output reg         end_of_sequence_flag_r,
  output reg         window_alarm_flag_r,
  output reg  [1:0]  irq_source_r,
  output reg  [2:0]  irq_level_r,
  output reg  [63:0] channel_data_r,
  output reg  [7:0]  lt6_r,
  output reg  [7:0]  lt7_r,
  output reg  [7:0]  ut6_r,
  output reg  [7:0]  ut7_r,
  output reg  [2:0]  mux_chan_r,
  output wire        sample_on,
  output wire [7:0]  sar_trial,
  output wire        conv_busy
);

  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;

  reg        state_r;
  reg        state_nxt;
  reg        cont_r;
  reg        tmr_en_r;
  reg        pin_en_r;
  reg  [2:0] first_chan_r;
  reg        pin_prev_r;
  reg        tmr_prev_r;
  reg  [3:0] cmp_flags_r;
  reg        run_nxt;
  reg  [2:0] chan_nxt;
  reg        sar_start;

  wire       sar_done;
  wire [7:0] sar_result;
  wire [3:0] win_hit;
  wire       pin_evt;
  wire       tmr_evt;
  wire       trig;
  wire       seq_end;
  wire       wa_req;
  wire       eos_req;

  ////////////////////////////////////////////////////////////////////////////////
  // Converter core and window monitor.

  aas_sar #(
    .CONV_CYCLES   (CONV_CYCLES),
    .SAMPLE_CYCLES (SAMPLE_CYCLES),
    .BIT_CYCLES    (BIT_CYCLES)
  ) u_sar (
    .clock    (clock),
    .rst_n    (rst_n),
    .start    (sar_start),
    .abort    (ctrl_wr),
    .comp_in  (comp_in),
    .busy_r   (conv_busy),
    .sample_r (sample_on),
    .trial_r  (sar_trial),
    .done_r   (sar_done),
    .result_r (sar_result)
  );

  aas_window u_win (
    .res_valid (sar_done),
    .res_chan  (mux_chan_r),
    .res_data  (sar_result),
    .lt6       (lt6_r),
    .lt7       (lt7_r),
    .ut6       (ut6_r),
    .ut7       (ut7_r),
    .hit       (win_hit)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Triggers. A falling edge is the start event, so a source stuck low starts once.

  assign pin_evt = pin_en_r && pin_prev_r && !pin_trigger_input;
  assign tmr_evt = tmr_en_r && tmr_prev_r && !timer_trigger_input;
  assign trig    = pin_evt || tmr_evt;

  assign seq_end = sar_done && (mux_chan_r == `AAS_LAST_CHAN);

  assign control_word = {first_chan_r, pin_en_r, tmr_en_r, analog_bias_on_r, cont_r,
                         conversion_run_r};

  assign compare_flags = {cmp_flags_r, `AAS_CMP_LOW_ONES};

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencing.

  always @*
  begin
    run_nxt   = conversion_run_r;
    chan_nxt  = mux_chan_r;
    state_nxt = state_r;
    sar_start = 1'b0;
    if (ctrl_wr)
    begin
      run_nxt   = ctrl_wdata[`AAS_CTL_RUN];
      chan_nxt  = ctrl_wdata[`AAS_CTL_FCS_HI:`AAS_CTL_FCS_LO];
      state_nxt = ST_IDLE;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (conversion_run_r)
          begin
            sar_start = 1'b1;
            state_nxt = ST_CONV;
          end
        end
        ST_CONV:
        begin
          if (sar_done)
          begin
            state_nxt = ST_IDLE;
            if (seq_end)
            begin
              chan_nxt = first_chan_r;
              if (!cont_r)
                run_nxt = 1'b0;
            end
            else
            begin
              chan_nxt = mux_chan_r + 3'h1;
            end
          end
        end
        default:
        begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
    if (trig && !conversion_run_r)
      run_nxt = 1'b1;
  end

  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_r          <= ST_IDLE;
      conversion_run_r <= 1'b0;
      cont_r           <= 1'b0;
      tmr_en_r         <= 1'b0;
      pin_en_r         <= 1'b0;
      first_chan_r     <= 3'h0;
      mux_chan_r       <= 3'h0;
      analog_bias_on_r <= 1'b0;
      pin_prev_r       <= 1'b0;
      tmr_prev_r       <= 1'b0;
    end
    else
    begin
      state_r          <= state_nxt;
      conversion_run_r <= run_nxt;
      mux_chan_r       <= chan_nxt;
      pin_prev_r       <= pin_trigger_input;
      tmr_prev_r       <= timer_trigger_input;
      if (ctrl_wr)
      begin
        cont_r       <= ctrl_wdata[`AAS_CTL_CONT];
        tmr_en_r     <= ctrl_wdata[`AAS_CTL_TMR_EN];
        pin_en_r     <= ctrl_wdata[`AAS_CTL_PIN_EN];
        first_chan_r <= ctrl_wdata[`AAS_CTL_FCS_HI:`AAS_CTL_FCS_LO];
      end
      if (halt_entry)
        analog_bias_on_r <= 1'b0;
      else if (ctrl_wr)
        analog_bias_on_r <= ctrl_wdata[`AAS_CTL_BIAS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result and threshold storage.

  // Channel index of a storage slot, cut to the multiplexer width on purpose.
  function [2:0] chan_id;
    input integer idx;
    begin
      chan_id = idx[2:0];
    end
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_data
      always @(posedge clock)
      begin
        if (!rst_n)
          channel_data_r[gi*8 +: 8] <= 8'h00;
        else if (sar_done && (mux_chan_r == chan_id(gi)))
          channel_data_r[gi*8 +: 8] <= sar_result;
      end
    end
  endgenerate

  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      lt6_r <= 8'h00;
      lt7_r <= 8'h00;
      ut6_r <= 8'h00;
      ut7_r <= 8'h00;
    end
    else if (thr_wr)
    begin
      case (thr_addr)
        `AAS_THR_LT6: lt6_r <= thr_wdata;
        `AAS_THR_LT7: lt7_r <= thr_wdata;
        `AAS_THR_UT6: ut6_r <= thr_wdata;
        `AAS_THR_UT7: ut7_r <= thr_wdata;
        default:      lt6_r <= lt6_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pending flags and request arbitration. Hardware sets win over software clears.

  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      cmp_flags_r            <= 4'h0;
      end_of_sequence_flag_r <= 1'b0;
      window_alarm_flag_r    <= 1'b0;
    end
    else
    begin
      if (irq_ctrl_wr && !irq_ctrl_wdata[`AAS_ICR_WA])
        cmp_flags_r <= win_hit;
      else
        cmp_flags_r <= cmp_flags_r | win_hit;
      if (irq_ctrl_wr)
      begin
        end_of_sequence_flag_r <= irq_ctrl_wdata[`AAS_ICR_EOS] || seq_end;
        window_alarm_flag_r    <= irq_ctrl_wdata[`AAS_ICR_WA] || (win_hit != 4'h0);
      end
      else
      begin
        end_of_sequence_flag_r <= end_of_sequence_flag_r || seq_end;
        window_alarm_flag_r    <= window_alarm_flag_r || (win_hit != 4'h0);
      end
    end
  end

  assign wa_req  = window_alarm_flag_r && wa_irq_enable;
  assign eos_req = end_of_sequence_flag_r && eos_irq_enable;

  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      irq_source_r <= `AAS_SRC_NONE;
      irq_level_r  <= 3'h0;
    end
    else
    begin
      if (wa_req)
        irq_source_r <= `AAS_SRC_WA;
      else if (eos_req)
        irq_source_r <= `AAS_SRC_EOS;
      else
        irq_source_r <= `AAS_SRC_NONE;
      irq_level_r <= (wa_req || eos_req) ? irq_priority : 3'h0;
    end
  end

endmodule // aas_seq

// File: rtl/aas_window.v
// Window comparison of a fresh channel 6 or 7 result against its thresholds.
// Assumes the result is valid only in the cycle that res_valid is high.
`timescale 1ns/10ps
`include "aas_defines.vh"

module aas_window (
  input  wire       res_valid,
  input  wire [2:0] res_chan,
  input  wire [7:0] res_data,
  input  wire [7:0] lt6,
  input  wire [7:0] lt7,
  input  wire [7:0] ut6,
  input  wire [7:0] ut7,
  output wire [3:0] hit
);

  wire is6;
  wire is7;

  assign is6 = res_valid && (res_chan == `AAS_MON_CHAN_A);
  assign is7 = res_valid && (res_chan == `AAS_LAST_CHAN);

  assign hit[3] = is7 && (res_data >= ut7);
  assign hit[2] = is6 && (res_data >= ut6);
  assign hit[1] = is7 && (res_data < lt7);
  assign hit[0] = is6 && (res_data < lt6);

endmodule // aas_window
